// File: include/sbsc_defs.svh
// Contract
// - Low brake output releases, high applies brake
// - No release during overtravel or unpowered motor
// - Terminal digit routes brake output, zero unused
// - Shared terminal driven by OR of signals
// - Brake applies at servo off, delay shifts
// - Running stop applies brake by speed condition
// - Speed threshold clamped to motor maximum
// - Stop digit selects braking then hold/coast
// - Stop mode applies on servo off, alarm, power
// - Small models force dynamic brake on power loss
// - Hold time 20 to 1000 ms, immediate
// - Short main power loss ignored within hold
// - Undervoltage or control loss voids ride-through
`ifndef SBSC_DEFS_SVH
`define SBSC_DEFS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SBSC_CLK_HZ        25000000
`define SBSC_TICK_MS       1
`define SBSC_TICK_CYCLES   (`SBSC_CLK_HZ / 1000 * `SBSC_TICK_MS)
`define SBSC_HOLD_MIN      10'd20
`define SBSC_HOLD_MAX      10'd1000
`define SBSC_HOLD_RESET    10'd20

// ------------------------------------------------------------
// Field codes
// ------------------------------------------------------------
`define SBSC_TERM_NONE     2'd0
`define SBSC_STOP_DB_DB    2'd0
`define SBSC_STOP_DB_COAST 2'd1
`define SBSC_STOP_COAST    2'd2

`endif

// File: include/sbsc_pkg.sv
package sbsc_pkg;
    // Stopping state of the power stage
    typedef enum logic [3:0] {
        SBSC_RUN   = 4'b0001,   // Motor powered by servo
        SBSC_DBRK  = 4'b0010,   // Dynamic braking active
        SBSC_COAST = 4'b0100,   // Power stage off
        SBSC_HOLD  = 4'b1000    // Dynamic brake held after stop
    } sbsc_state_e;

    // Status inputs grouped together
    typedef struct packed {
        logic servo_on;          // Host servo-on request
        logic alarm;             // Any alarm active
        logic main_power;        // Main circuit present
        logic ctrl_power;        // Control supply present
        logic undervolt;         // Undervoltage alarm
        logic overtravel;        // Overtravel active
        logic stopped;           // Motor at standstill
    } sbsc_status_s;

    // Power stage commands
    typedef struct packed {
        logic powered;           // Motor current enabled
        logic dyn_brake;         // Dynamic braking shorted
    } sbsc_stage_s;
endpackage : sbsc_pkg

// File: core/sbsc_ctrl.sv
`timescale 1ns/100ps
`include "sbsc_defs.svh"
module sbsc_ctrl #(
    parameter int SPD_W      = 16,     // Speed word width
    parameter int OFF_DLY_MS = 0,      // Servo-off delay after brake, ms
    parameter int TICK_CYC   = `SBSC_TICK_CYCLES,
    parameter bit SMALL_MODEL = 1'b0   // Forces braking on power loss
) (
    input  wire logic                 clock_i,         // 25 MHz clock
    input  wire logic                 rst_n_i,         // Async reset
    input  wire sbsc_pkg::sbsc_status_s status_i,      // Status inputs
    input  wire logic [SPD_W-1:0]     speed_i,         // Motor speed magnitude
    input  wire logic [SPD_W-1:0]     brake_speed_threshold_i, // Brake speed
    input  wire logic [SPD_W-1:0]     max_speed_i,     // Motor maximum speed
    input  wire logic [9:0]           power_loss_hold_time_i, // Hold ms
    input  wire logic [1:0]           output_terminal_assign_param_i, // Route
    input  wire logic [1:0]           stop_method_param_i, // Stop digit
    input  wire logic [2:0]           other_out_i,     // Other functions per terminal
    output logic [2:0]                term_o,          // Terminals, low active
    output logic                      brake_release_out_n_o, // Brake signal
    output sbsc_pkg::sbsc_stage_s     stage_o,         // Stage commands
    output logic                      servo_active_o   // Servo running
);
    initial begin
        if (SPD_W < 2 || OFF_DLY_MS < 0 || OFF_DLY_MS > 1000 || TICK_CYC < 1)
            $error("sbsc_ctrl: bad parameter");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Clamp value to a limit
    function automatic logic [SPD_W-1:0] clamp_f(input logic [SPD_W-1:0] v,
                                                 input logic [SPD_W-1:0] lim);
        clamp_f = (v > lim) ? lim : v;
    endfunction : clamp_f

    // Clamp hold setting to legal range
    function automatic logic [9:0] hold_f(input logic [9:0] v);
        if (v < `SBSC_HOLD_MIN)
            hold_f = `SBSC_HOLD_MIN;
        else if (v > `SBSC_HOLD_MAX)
            hold_f = `SBSC_HOLD_MAX;
        else
            hold_f = v;
    endfunction : hold_f

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam logic [9:0]  OFF_DLY   = 10'(OFF_DLY_MS);

    // ------------------------------------------------------------
    // Millisecond tick and ride-through
    // ------------------------------------------------------------
    logic [15:0] tick_reg, tick_next;     // Prescaler
    logic        ms_reg, ms_next;         // One-cycle ms strobe
    logic [9:0]  loss_reg, loss_next;     // Ms of missing main power
    logic        trip_reg, trip_next;     // Ride-through expired
    logic        loss_now;                // Power loss counts as off

    // Prescaler and power-loss counter
    always_comb begin
        tick_next = (tick_reg == TICK_LAST) ? 16'h0 : tick_reg + 16'h1;
        ms_next   = (tick_reg == TICK_LAST);
        loss_next = loss_reg;
        trip_next = trip_reg;
        if (status_i.main_power) begin
            loss_next = 10'h0;
            trip_next = 1'b0;
        end else if (ms_reg && !trip_reg) begin
            loss_next = loss_reg + 10'h1;
            if (loss_reg + 10'h1 >= hold_f(power_loss_hold_time_i))
                trip_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tick_reg <= 16'h0;
            ms_reg   <= 1'b0;
            loss_reg <= 10'h0;
            trip_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            ms_reg   <= ms_next;
            loss_reg <= loss_next;
            trip_reg <= trip_next;
        end
    end

    assign loss_now = trip_reg || !status_i.ctrl_power ||
                      (!status_i.main_power && status_i.undervolt);

    // ------------------------------------------------------------
    // Servo off request and stop state machine
    // ------------------------------------------------------------
    logic stop_req;                       // Any stop cause
    logic pwr_off;                        // Power-off cause
    sbsc_pkg::sbsc_state_e st_reg, st_next;
    logic [9:0]  dly_reg, dly_next;       // Servo-off delay counter
    logic        brk_reg, brk_next;       // Brake applied internally
    logic [SPD_W-1:0] thr;                // Clamped threshold

    assign pwr_off  = loss_now;
    assign stop_req = !status_i.servo_on || status_i.alarm || pwr_off;
    assign thr = clamp_f(brake_speed_threshold_i, max_speed_i);

    // Brake and stop sequencing
    always_comb begin
        st_next  = st_reg;
        dly_next = dly_reg;
        brk_next = brk_reg;
        case (st_reg)
            sbsc_pkg::SBSC_RUN: begin
                brk_next = 1'b0;
                dly_next = 10'h0;
                if (stop_req) begin
                    if (status_i.stopped) begin
                        brk_next = 1'b1;
                        if (OFF_DLY != 10'h0 && !pwr_off && !status_i.alarm) begin
                            st_next = sbsc_pkg::SBSC_RUN;
                            dly_next = dly_reg;
                        end
                    end else if (speed_i <= thr) begin
                        brk_next = 1'b1;
                    end
                    if (!status_i.stopped || OFF_DLY == 10'h0 || pwr_off ||
                        status_i.alarm || (dly_reg >= OFF_DLY)) begin
                        if (SMALL_MODEL && pwr_off)
                            st_next = sbsc_pkg::SBSC_DBRK;
                        else if (stop_method_param_i == `SBSC_STOP_COAST)
                            st_next = sbsc_pkg::SBSC_COAST;
                        else
                            st_next = sbsc_pkg::SBSC_DBRK;
                    end else if (ms_reg) begin
                        dly_next = dly_reg + 10'h1;
                    end
                end
            end
            sbsc_pkg::SBSC_DBRK: begin
                if (speed_i <= thr)
                    brk_next = 1'b1;
                if (status_i.stopped) begin
                    brk_next = 1'b1;
                    if (stop_method_param_i == `SBSC_STOP_DB_COAST && !(SMALL_MODEL && pwr_off))
                        st_next = sbsc_pkg::SBSC_COAST;
                    else
                        st_next = sbsc_pkg::SBSC_HOLD;
                end
            end
            sbsc_pkg::SBSC_COAST, sbsc_pkg::SBSC_HOLD: begin
                if (speed_i <= thr || status_i.stopped)
                    brk_next = 1'b1;
                if (!stop_req)
                    st_next = sbsc_pkg::SBSC_RUN;
            end
            default: st_next = sbsc_pkg::SBSC_COAST;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg  <= sbsc_pkg::SBSC_HOLD;
            dly_reg <= 10'h0;
            brk_reg <= 1'b1;
        end else begin
            st_reg  <= st_next;
            dly_reg <= dly_next;
            brk_reg <= brk_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs and terminal routing
    // ------------------------------------------------------------
    logic       bk_n;                     // Brake line, low releases
    logic [2:0] term_next;

    // Output computation
    // The brake line is built from the next state values, so that the
    // brake applies on the very edge at which the servo drops out.
    // Using the registered values instead would leave the brake released
    // for one cycle after the stage has already lost its drive.
    // While a stop without a power-off cause or overtravel is running the brake stays released until the speed
    // condition is met, which keeps the holding brake from being used
    // as a running brake; the power stage alone slows the motor then.
    // Trade-off: the line follows the status inputs combinationally into
    // one flip-flop, so those inputs must be clean and synchronous.
    always_comb begin
        // no release on overtravel or unpowered
        // Unpowered means a power-off cause: main loss past ride-through,
        // control supply gone, or undervoltage during the loss
        bk_n = brk_next || status_i.overtravel || pwr_off;
        term_next = 3'b111;
        for (int i = 0; i < 3; i++) begin
            if (output_terminal_assign_param_i == 2'(i + 1))
                term_next[i] = bk_n & other_out_i[i];
            else
                term_next[i] = other_out_i[i];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_o                <= 3'b111;
            brake_release_out_n_o <= 1'b1;
            stage_o               <= '{powered: 1'b0, dyn_brake: 1'b1};
            servo_active_o        <= 1'b0;
        end else begin
            term_o                <= term_next;
            brake_release_out_n_o <= bk_n;
            stage_o.powered       <= (st_next == sbsc_pkg::SBSC_RUN);
            stage_o.dyn_brake     <= (st_next == sbsc_pkg::SBSC_DBRK) ||
                                     (st_next == sbsc_pkg::SBSC_HOLD);
            servo_active_o        <= (st_next == sbsc_pkg::SBSC_RUN);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // The checks watch registered outputs, internal state, and the status and setting inputs.
    // Each one names the rule that it guards at the end of its label.
    // The properties below are single step and bounded by one cycle,
    // so a failure points straight at the offending edge.

    // Stop asked for while the motor stands, no servo-off delay
    sequence s_still_stop;
        st_reg == sbsc_pkg::SBSC_RUN && stop_req && status_i.stopped &&
        OFF_DLY_MS == 0;
    endsequence

    // Brake applied and servo dropped on the same edge
    sequence s_brake_and_off;
        brake_release_out_n_o && !servo_active_o;
    endsequence

    // Any stop cause with no servo-off delay configured
    sequence s_any_stop;
        stop_req && OFF_DLY_MS == 0;
    endsequence

    // Power stage no longer driving the motor
    sequence s_unpowered;
        !stage_o.powered && !servo_active_o;
    endsequence

    a_brake_with_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_still_stop |=> s_brake_and_off)
        else $error("brake and servo off not together");

    a_stop_unpowers: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_any_stop |=> s_unpowered)
        else $error("stage still powered after stop cause");

    a_no_release_loss: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        pwr_off |=> brake_release_out_n_o)
        else $error("brake released without power");

    a_no_release_ot: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        status_i.overtravel |=> brake_release_out_n_o)
        else $error("brake released during overtravel");
    a_coast_mode: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (st_reg == sbsc_pkg::SBSC_RUN && stop_req && !status_i.stopped && !SMALL_MODEL
         && stop_method_param_i == `SBSC_STOP_COAST) |=> st_reg == sbsc_pkg::SBSC_COAST)
        else $error("coast mode not taken");
    a_unrouted_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (output_terminal_assign_param_i == `SBSC_TERM_NONE) |=> term_o == $past(other_out_i))
        else $error("unrouted brake reached a terminal");
    a_trip_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        status_i.main_power |=> !trip_reg)
        else $error("trip while main power present");
endmodule : sbsc_ctrl

// File: sim/sbsc_host_model.sv
`timescale 1ns/100ps
module sbsc_host_model (
    input  wire logic        clock_i,     // Bench clock
    input  wire logic        rst_n_i,     // Async reset, low active
    input  wire logic        brake_n_i,   // Brake release line, low active
    input  wire logic [15:0] req_speed_i, // Speed the host wants
    output logic             held_o,      // Relay holds the brake
    output logic [15:0]      speed_o      // Reference the motor follows
);
    logic held_reg;  // Relay contact state
    logic held_next; // Relay next state
    always_comb held_next = brake_n_i;
    // Relay register, brake held out of reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) held_reg <= 1'b1;
        else held_reg <= held_next;
    end
    assign held_o = held_reg;
    // reference zeroed while brake line high
    // Host stops by reference, so the motor sees no torque demand under brake
    assign speed_o = brake_n_i ? 16'h0000 : req_speed_i;
endmodule : sbsc_host_model

// File: sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic                   clock_i;    // Bench clock
    logic                   rst_n_i;    // Reset, low active
    sbsc_pkg::sbsc_status_s st;         // Status inputs
    logic [15:0]            req_spd;    // Host speed wish
    logic [15:0]            spd;        // Speed after host
    logic [15:0]            thr;        // Brake speed threshold
    logic [15:0]            vmax;       // Motor maximum speed
    logic [9:0]             hold;       // Loss hold, ms
    logic [1:0]             route;      // Terminal selection
    logic [1:0]             mode;       // Stop method digit
    logic [2:0]             oth;        // Other terminal functions
    logic [2:0]             term;       // Terminals
    logic                   brk_n;      // Brake line
    sbsc_pkg::sbsc_stage_s  stage;      // Stage commands
    logic                   act;        // Servo active
    logic                   held;       // Relay state
    int                     n_mismatch; // Mismatches
    int                     checks;     // Compares
    // ------------------------------------------------------------
    // Design, partner and clock
    // ------------------------------------------------------------
    sbsc_ctrl #(.TICK_CYC(10)) dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .status_i(st),
        .speed_i(spd), .brake_speed_threshold_i(thr), .max_speed_i(vmax),
        .power_loss_hold_time_i(hold), .output_terminal_assign_param_i(route),
        .stop_method_param_i(mode), .other_out_i(oth), .term_o(term),
        .brake_release_out_n_o(brk_n), .stage_o(stage), .servo_active_o(act));
    sbsc_host_model host_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .brake_n_i(brk_n),
        .req_speed_i(req_spd), .held_o(held), .speed_o(spd));
    always #20 clock_i = ~clock_i;
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic end_sim;
        $display("Counts: mismatches=%0d checks=%0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // Bounded wait on servo active (sel 0) or brake line (sel 1)
    task automatic wait_lvl(input bit sel, input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clock_i);
            if ((sel ? brk_n : act) === v) return;
        end
        $display("MISMATCH t=%0t got=%h exp=%h", $time, ~v, v);
        n_mismatch++;
        end_sim();
    endtask : wait_lvl
    task automatic nc(input int n);
        repeat (n) @(negedge clock_i);
    endtask : nc
    // Back to running with all causes cleared
    task automatic up;
        @(posedge clock_i);
        st <= 7'h59;
        req_spd <= 16'h0000;
        wait_lvl(1'b0, 1'b1, 20);
        wait_lvl(1'b1, 1'b0, 10);
    endtask : up
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_route;
        for (int r = 0; r < 4; r++) begin
            @(posedge clock_i);
            route <= 2'(r);
            nc(3);
            chk(term, (r == 0) ? 16'h0007 : 16'h0007 ^ (16'h0001 << (r - 1)));
        end
        @(posedge clock_i);
        oth <= 3'h6;
        st.servo_on <= 1'b0;
        wait_lvl(1'b1, 1'b1, 6);
        nc(2);
        chk(term, 3'h6);
        @(posedge clock_i);
        oth <= 3'h7;
        route <= 2'h1;
        up();
        chk(term, 3'h6);
    endtask : t_route
    task automatic t_overtravel;
        @(posedge clock_i);
        st.overtravel <= 1'b1;
        wait_lvl(1'b1, 1'b1, 5);
        nc(6);
        chk(brk_n, 1'b1);
        chk(held, 1'b1);
        up();
    endtask : t_overtravel
    // Every stop digit under servo off and under alarm
    task automatic t_stop;
        for (int m = 0; m < 3; m++) begin
            for (int c = 0; c < 2; c++) begin
                @(posedge clock_i);
                mode <= 2'(m);
                if (c == 0) st.servo_on <= 1'b0;
                else st.alarm <= 1'b1;
                wait_lvl(1'b0, 1'b0, 5);
                chk(brk_n, 1'b1);
                nc(6);
                chk(stage, {1'b0, m == 0});
                chk(stage.powered, 1'b0);
                up();
            end
        end
        @(posedge clock_i);
        mode <= 2'h0;
    endtask : t_stop
    // Threshold 500 above maximum 300: speed 400 keeps brake released
    task automatic t_running;
        @(posedge clock_i);
        thr <= 16'h01f4;
        vmax <= 16'h012c;
        req_spd <= 16'h0190;
        st.stopped <= 1'b0;
        nc(3);
        @(posedge clock_i);
        st.servo_on <= 1'b0;
        nc(8);
        chk(brk_n, 1'b0);
        @(posedge clock_i);
        req_spd <= 16'h012c;
        wait_lvl(1'b1, 1'b1, 5);
        chk(spd, 16'h0000);
        up();
    endtask : t_running
    // Hold of 20 ms at 10 cycles a tick is 200 cycles
    task automatic t_loss;
        @(posedge clock_i);
        st.main_power <= 1'b0;
        nc(150);
        chk(act, 1'b1);
        @(posedge clock_i);
        st.main_power <= 1'b1;
        nc(5);
        chk(act, 1'b1);
        @(posedge clock_i);
        hold <= 10'h005;
        st.main_power <= 1'b0;
        nc(190);
        chk(act, 1'b1);
        wait_lvl(1'b0, 1'b0, 40);
        nc(4);
        chk(stage, 2'h1);
        up();
        @(posedge clock_i);
        st.main_power <= 1'b0;
        st.undervolt <= 1'b1;
        wait_lvl(1'b0, 1'b0, 5);
        up();
        @(posedge clock_i);
        st.ctrl_power <= 1'b0;
        wait_lvl(1'b0, 1'b0, 5);
        chk(brk_n, 1'b1);
        up();
    endtask : t_loss
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        st = 7'h59;
        {req_spd, thr, vmax} = {16'h0000, 16'h0064, 16'h0bb8};
        {hold, route, mode, oth} = {10'h014, 2'h0, 2'h0, 3'h7};
        n_mismatch = 0;
        checks = 0;
        repeat (2) @(posedge clock_i);
        chk({term, brk_n, stage, act}, 7'h7a);
        rst_n_i <= 1'b1;
        wait_lvl(1'b0, 1'b1, 20);
        wait_lvl(1'b1, 1'b0, 10);
        t_route();
        t_overtravel();
        t_stop();
        t_running();
        t_loss();
        end_sim();
    end
endmodule : testbench
